// file: src/clk_temp_regs.vh
// Purpose: Register offsets, field positions, reset values and timing counts.
// Assumes: 8-bit register port, 40 MHz core clock.
// Notes: Definitions only.
`ifndef CLK_TEMP_REGS_VH
`define CLK_TEMP_REGS_VH
`define ADDR_DIE_TEMP 8'h31
`define ADDR_INT_DET1 8'h26
`define ADDR_LOW_PWR 8'h35
`define ADDR_RATE 8'h36
`define ADDR_CLK_CFG1 8'h4f
`define ADDR_CLK_CFG2 8'h50
`define RST_LOW_PWR 8'h00
`define RST_RATE 8'h32
`define RST_CLK_CFG1 8'h00
`define RST_CLK_CFG2 8'h11
`define BIT_TEMP_REQ 5
`define BIT_TEMP_VALID 4
`define BIT_POR_OFF 7
`define BIT_F2_SEL 3
`define BIT_F1_SEL 2
`define BIT_CLK_FAULT1_STICKY_FLAG 5
// Counts in 40 MHz core clock cycles: 1 us acquisition, 10.6 us timeout step, 15 us per dB.
`define TEMP_CONV_CYC 16'd40
`define TO_BASE_CYC 22'd424
`define RAMP_BASE_CYC 13'd600
`endif

// file: src/clk_temp_bank.v
// Purpose: Register bank for die temperature, POR power, sample rate and clock faults.
// Assumes: Byte-wide register port on clk_in; fault and clock-activity inputs from pins.
// Notes: Reads return data on the cycle after rd_in.
// Operation
// - Writing one to request starts a temperature acquisition; bit clears when done.
// - Valid flag stays low during acquisition and rises only with a valid code.
// - Last measurement is reported as a 4-bit ascending band code.
// - Battery reset monitor is powered when its bit is zero, off when one.
// - Two-bit field selects sample rate 8, 16, 48 or 96 kHz.
// - Fault two recovers automatically when bit zero, else latches shutdown.
// - Fault one recovers automatically when bit zero, else latches shutdown.
// - On clock fault gain ramps down at a rate picked by a 2-bit field.
// - Playback mutes when no clock reaches detector one for selected timeout.
// - Sticky flag sets on clock fault one and clears when flag register read.
`timescale 1ns/1ps
`default_nettype none
`include "clk_temp_regs.vh"
module clk_temp_bank (
  input wire clk_in,
  input wire rst_in,
  input wire wr_in,
  input wire rd_in,
  input wire [7:0] addr_in,
  input wire [7:0] wdata_in,
  output reg [7:0] rdata_out,
  input wire [3:0] temp_code_in,
  input wire fault1_in,
  input wire fault2_in,
  input wire clk1_tick_in,
  input wire host_recover_in,
  output reg por_power_down_out,
  output reg [1:0] sample_rate_out,
  output reg [1:0] fault_gain_ramp_rate_out,
  output reg ramp_step_out,
  output reg mute_out,
  output reg shutdown_out
);
  localparam ST_IDLE = 2'b01;
  localparam ST_CONV = 2'b10;
  reg [1:0] state;
  reg [15:0] conv_cnt;
  reg temp_read_request;
  reg temp_result_valid;
  reg [3:0] temp_band_code;
  reg [7:0] low_power_config;
  reg [7:0] input_sample_rate_config;
  reg [7:0] clock_fault_recovery_config;
  reg [7:0] clock_fault_ramp_timeout_config;
  reg clk_fault1_sticky_flag;
  reg [1:0] s_f1, s_f2;
  reg [2:0] s_tk, s_rc;
  reg [3:0] t_s1, t_s2, t_s3;
  reg [21:0] idle_cnt;
  reg idle_fault;
  reg latch1, latch2;
  reg [12:0] ramp_cnt;
  wire f1 = s_f1[1] | idle_fault;
  wire f2 = s_f2[1];
  wire any_fault = f1 | f2 | latch1 | latch2;
  wire rd_flags = rd_in && addr_in == `ADDR_INT_DET1;
  function [21:0] timeout_cycles;
    input [2:0] code;
    // Codes four and up add one doubling, so the longest window is about 2.7 ms.
    if (code[2])
      timeout_cycles = (`TO_BASE_CYC << ({1'b0, code} + 4'd1)) - 22'd1;
    else
      timeout_cycles = (`TO_BASE_CYC << code) - 22'd1;
  endfunction
  function [12:0] ramp_cycles;
    input [1:0] code;
    ramp_cycles = (`RAMP_BASE_CYC << code) - 13'd1;
  endfunction
  // Pins cross into clk_in through two stages; logic reads stage two and later only.
  // Tick and sensor code keep a third stage so edges and changes can be seen; recovery is read at stage three as a level.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_f1 <= 2'h0;
      s_f2 <= 2'h0;
      s_tk <= 3'h0;
      s_rc <= 3'h0;
      t_s1 <= 4'h0;
      t_s2 <= 4'h0;
      t_s3 <= 4'h0;
    end else begin
      s_f1 <= {s_f1[0], fault1_in};
      s_f2 <= {s_f2[0], fault2_in};
      s_tk <= {s_tk[1], s_tk[0], clk1_tick_in};
      s_rc <= {s_rc[1], s_rc[0], host_recover_in};
      t_s1 <= temp_code_in;
      t_s2 <= t_s1;
      t_s3 <= t_s2;
    end
  end
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
      conv_cnt <= 16'h0000;
      temp_read_request <= 1'b0;
      temp_result_valid <= 1'b0;
      temp_band_code <= 4'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (wr_in && addr_in == `ADDR_DIE_TEMP && wdata_in[`BIT_TEMP_REQ]) begin
            temp_read_request <= 1'b1;
            temp_result_valid <= 1'b0;
            conv_cnt <= 16'h0000;
            state <= ST_CONV;
          end
        end
        ST_CONV: begin
          // The sensor code is a word from another domain with no handshake, so it is
          // taken only once two successive synchronised samples agree; a code caught
          // mid-change stretches the acquisition instead of storing a mixed value.
          if (conv_cnt == `TEMP_CONV_CYC - 16'd1) begin
            if (t_s2 == t_s3) begin
              temp_read_request <= 1'b0;
              temp_band_code <= t_s3;
              temp_result_valid <= 1'b1;
              state <= ST_IDLE;
            end
          end else begin
            conv_cnt <= conv_cnt + 16'd1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      low_power_config <= `RST_LOW_PWR;
      input_sample_rate_config <= `RST_RATE;
      clock_fault_recovery_config <= `RST_CLK_CFG1;
      clock_fault_ramp_timeout_config <= `RST_CLK_CFG2;
    end else if (wr_in) begin
      // Writes to read-only or unmapped addresses fall through and change nothing.
      case (addr_in)
        `ADDR_LOW_PWR: low_power_config <= wdata_in;
        `ADDR_RATE: input_sample_rate_config <= wdata_in;
        `ADDR_CLK_CFG1: clock_fault_recovery_config <= wdata_in;
        `ADDR_CLK_CFG2: clock_fault_ramp_timeout_config <= wdata_in;
        default: ;
      endcase
    end
  end
  // Missing clock: count cycles since last detector-one tick edge.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      idle_cnt <= 22'h0;
      idle_fault <= 1'b0;
    end else if (s_tk[2] != s_tk[1]) begin
      idle_cnt <= 22'h0;
      idle_fault <= 1'b0;
    end else if (idle_cnt >= timeout_cycles(clock_fault_ramp_timeout_config[5:3])) begin
      idle_fault <= 1'b1;
    end else begin
      idle_cnt <= idle_cnt + 22'd1;
    end
  end
  // Latched shutdown holds until the host pulses recovery; set wins over recovery.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      latch1 <= 1'b0;
      latch2 <= 1'b0;
      clk_fault1_sticky_flag <= 1'b0;
    end else begin
      if (f1 && clock_fault_recovery_config[`BIT_F1_SEL])
        latch1 <= 1'b1;
      else if (s_rc[2])
        latch1 <= 1'b0;
      if (f2 && clock_fault_recovery_config[`BIT_F2_SEL])
        latch2 <= 1'b1;
      else if (s_rc[2])
        latch2 <= 1'b0;
      if (f1)
        clk_fault1_sticky_flag <= 1'b1;
      else if (rd_flags)
        clk_fault1_sticky_flag <= 1'b0;
    end
  end
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ramp_cnt <= 13'h0;
      ramp_step_out <= 1'b0;
      mute_out <= 1'b0;
      shutdown_out <= 1'b0;
      por_power_down_out <= 1'b0;
      sample_rate_out <= 2'h0;
      fault_gain_ramp_rate_out <= 2'h0;
    end else begin
      por_power_down_out <= low_power_config[`BIT_POR_OFF];
      sample_rate_out <= input_sample_rate_config[1:0];
      fault_gain_ramp_rate_out <= clock_fault_ramp_timeout_config[7:6];
      mute_out <= any_fault;
      shutdown_out <= latch1 | latch2;
      ramp_step_out <= 1'b0;
      // The step timer restarts whenever every fault has cleared, so each fault begins
      // with a full step period before the first one-dB step.
      if (!any_fault) begin
        ramp_cnt <= 13'h0;
      end else if (ramp_cnt >= ramp_cycles(clock_fault_ramp_timeout_config[7:6])) begin
        ramp_cnt <= 13'h0;
        ramp_step_out <= 1'b1;
      end else begin
        ramp_cnt <= ramp_cnt + 13'd1;
      end
    end
  end
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      case (addr_in)
        `ADDR_DIE_TEMP: rdata_out <= {2'b00, temp_read_request, temp_result_valid,
                                      temp_band_code};
        `ADDR_INT_DET1: rdata_out <= {2'b00, clk_fault1_sticky_flag, 5'b00000};
        `ADDR_LOW_PWR: rdata_out <= low_power_config;
        `ADDR_RATE: rdata_out <= input_sample_rate_config;
        `ADDR_CLK_CFG1: rdata_out <= clock_fault_recovery_config;
        `ADDR_CLK_CFG2: rdata_out <= clock_fault_ramp_timeout_config;
        default: rdata_out <= 8'h00;
      endcase
    end
  end
endmodule // clk_temp_bank
`default_nettype wire

// file: testbench/clk_temp_bank_asserts.sv
// Purpose: Port-level checks for clk_temp_bank.
// Assumes: Inputs change just after the rising clk_in edge.
// Notes: Windows leave room for the two-flop input synchronisers.
`timescale 1ns/1ps
`default_nettype none
module clk_temp_bank_asserts (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [7:0] rdata_out,
  input wire logic fault1_in,
  input wire logic host_recover_in,
  input wire logic por_power_down_out,
  input wire logic [1:0] sample_rate_out,
  input wire logic [1:0] fault_gain_ramp_rate_out,
  input wire logic ramp_step_out,
  input wire logic mute_out,
  input wire logic shutdown_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_por_follow: assert property (
    wr_in && addr_in == 8'h35 ##1 !wr_in |=> por_power_down_out == $past(wdata_in[7], 2))
    else $error("power-down output wrong");
  a_rate_follow: assert property (
    wr_in && addr_in == 8'h36 ##1 !wr_in |=> sample_rate_out == $past(wdata_in[1:0], 2))
    else $error("sample rate output wrong");
  a_ramp_follow: assert property (
    wr_in && addr_in == 8'h50 ##1 !wr_in |=>
    fault_gain_ramp_rate_out == $past(wdata_in[7:6], 2)) else $error("ramp rate output wrong");
  a_busy_invalid: assert property (
    rd_in && addr_in == 8'h31 ##1 rdata_out[5] |-> !rdata_out[4]) else $error("valid while busy");
  a_shut_hold: assert property (
    (shutdown_out && !host_recover_in) [*5] |=> shutdown_out) else $error("shutdown dropped");
  a_mute_fault: assert property (
    fault1_in [*5] |-> mute_out) else $error("no mute on fault");
  a_step_pulse: assert property (
    ramp_step_out |-> mute_out ##1 !ramp_step_out) else $error("bad ramp step");
  a_sticky_read: assert property (
    fault1_in [*4] ##1 rd_in && addr_in == 8'h26 |=> rdata_out[5]) else $error("flag not seen");
  c_shut: cover property ($rose(shutdown_out));
  c_step: cover property (ramp_step_out);
  c_mute: cover property ($rose(mute_out) && !fault1_in);
endmodule // clk_temp_bank_asserts
`default_nettype wire

// file: testbench/clk_temp_bank_tb_top.sv
// Purpose: Self-checking bench for clk_temp_bank.
// Assumes: 40 MHz clock; one-cycle read latency.
// Notes: Register rows first, then temperature, fault, timeout and mid-run reset cases.
`timescale 1ns/1ps
`default_nettype none
module clk_temp_bank_tb_top;
  logic clk_in = 0, rst_in = 1, wr_in = 0, rd_in = 0, f1 = 0, f2 = 0, tick = 0, ten = 1, rec = 0;
  logic [7:0] addr = 0, wdata = 0, rdata;
  logic [3:0] code = 0;
  logic por, step, mute, shut;
  logic [1:0] rate, ramp;
  int n_fail = 0, checked = 0, k, j, q[$];
  logic [31:0] rows [0:17] = '{32'h00350000, 32'h00360032, 32'h004f0000, 32'h00500011,
    32'h00310000, 32'h00000000, 32'h01358080, 32'h01360101, 32'h01360202, 32'h01360303,
    32'h01360000, 32'h014f0c0c, 32'h01504040, 32'h01508080, 32'h0150c0c0, 32'h01500000,
    32'h01005a00, 32'h0126ff00};
  clk_temp_bank DUT (.clk_in(clk_in), .rst_in(rst_in), .wr_in(wr_in), .rd_in(rd_in),
    .addr_in(addr), .wdata_in(wdata), .rdata_out(rdata), .temp_code_in(code), .fault1_in(f1),
    .fault2_in(f2), .clk1_tick_in(tick), .host_recover_in(rec), .por_power_down_out(por),
    .sample_rate_out(rate), .fault_gain_ramp_rate_out(ramp), .ramp_step_out(step),
    .mute_out(mute), .shutdown_out(shut));
  always #12.5 clk_in = ~clk_in;
  always @(posedge clk_in) if (ten) tick <= ~tick;
  task automatic chk(input string what, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_in) begin wr_in <= 1; addr <= a; wdata <= d; end
    @(posedge clk_in) wr_in <= 0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk_in) begin rd_in <= 1; addr <= a; end
    @(posedge clk_in) rd_in <= 0;
    @(posedge clk_in) chk("rdata", {8'h0, e}, {8'h0, rdata});
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_in);
    rst_in <= 0;
    for (k = 0; k < 18; k++) begin
      if (rows[k][24]) wr(rows[k][23:16], rows[k][15:8]);
      rd(rows[k][23:16], rows[k][7:0]);
    end
    chk("outputs", 16'h80, {8'h0, por, rate, ramp, step, mute, shut});
    $display("registers done");
    for (k = 0; k < 2; k++) begin
      code <= k ? 4'hf : 4'h0;
      wr(8'h31, 8'h20);
      rd(8'h31, 8'h20);
      repeat (60) @(posedge clk_in);
      rd(8'h31, {4'h1, code});
    end
    $display("temperature done");
    wr(8'h4f, 8'h04);
    f1 <= 1;
    repeat (20) @(posedge clk_in);
    rd(8'h26, 8'h20);
    f1 <= 0;
    repeat (10) @(posedge clk_in);
    chk("latched", 16'h3, {14'h0, shut, mute});
    rd(8'h26, 8'h20);
    rd(8'h26, 8'h00);
    rec <= 1;
    repeat (5) @(posedge clk_in);
    rec <= 0;
    repeat (5) @(posedge clk_in);
    chk("recovered", 16'h0, {14'h0, shut, mute});
    for (j = 0; j < 4; j++) begin
      wr(8'h50, 8'(j << 6));
      f2 <= 1;
      q.delete();
      for (k = 0; k < (1230 << j); k++) @(posedge clk_in) if (step === 1'b1) q.push_back(k);
      f2 <= 0;
      chk("ramp period", 16'(600 << j), 16'(q[1] - q[0]));
      repeat (10) @(posedge clk_in);
      chk("auto recovery", 16'h0, {14'h0, shut, mute});
    end
    $display("faults done");
    wr(8'h4f, 8'h00);
    for (j = 0; j < 2; j++) begin
      wr(8'h50, j ? 8'h20 : 8'h00);
      ten <= 0;
      repeat ((424 << (5 * j)) - 10) @(posedge clk_in);
      chk("early mute", 16'h0, {15'h0, mute});
      repeat (40) @(posedge clk_in);
      chk("idle mute", 16'h1, {15'h0, mute});
      ten <= 1;
      repeat (20) @(posedge clk_in);
      chk("tick restored", 16'h0, {15'h0, mute});
    end
    $display("timeout done");
    rst_in <= 1;
    repeat (2) @(posedge clk_in);
    chk("reset outputs", 16'h0, {8'h0, por, rate, ramp, step, mute, shut});
    rst_in <= 0;
    rd(8'h36, 8'h32);
    rd(8'h31, 8'h00);
    rd(8'h26, 8'h00);
    $display("reset done");
    final_report;
  end
  initial begin
    repeat (60000) @(posedge clk_in);
    n_fail++;
    $display("watchdog expired");
    final_report;
  end
endmodule // clk_temp_bank_tb_top
bind clk_temp_bank clk_temp_bank_asserts u_chk (.clk_in, .rst_in, .wr_in, .rd_in, .addr_in,
  .wdata_in, .rdata_out, .fault1_in, .host_recover_in, .por_power_down_out, .sample_rate_out,
  .fault_gain_ramp_rate_out, .ramp_step_out, .mute_out, .shutdown_out);
`default_nettype wire
